// *** core/dbe_burst.sv ***
/*
 * Burst access engine of a DDR2 memory device with an APB register slave.
 * Assumes the DDR clock is far slower than pclk, so its edges and the strobe
 * edges are found by oversampling after two synchronising flip-flops.
 */
`timescale 1ns/100ps
module dbe_burst (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe,
    input wire logic dqs_in,
    output logic dqs_out,
    output logic dqs_oe,
    input wire logic [1:0] dm
);

    // ------------------------
    // Pin synchronisers
    // ------------------------
    dbe_pkg::dbe_pins_t p1;
    dbe_pkg::dbe_pins_t p2;
    dbe_pkg::dbe_pins_t p3;
    dbe_pkg::dbe_pins_t next_p1;

    always_comb begin
        next_p1 = '{ck: ck, cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n,
                    ba: ba, addr: addr, dq: dq_in, dqs: dqs_in, dm: dm};
    end

    // The third stage holds the level just before an edge, where setup is met.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1 <= '0;
            p2 <= '0;
            p3 <= '0;
        end else begin
            p1 <= next_p1;
            p2 <= p1;
            p3 <= p2;
        end
    end

    logic tick;
    logic ck_edge;
    logic dqs_rise;
    logic dqs_edge;
    logic [3:0] cmd;
    assign tick = p2.ck & ~p3.ck;
    assign ck_edge = p2.ck ^ p3.ck;
    assign dqs_rise = p2.dqs & ~p3.dqs;
    assign dqs_edge = p2.dqs ^ p3.dqs;
    assign cmd = {p3.cs_n, p3.ras_n, p3.cas_n, p3.we_n};

    // ------------------------
    // Mode, banks and counters
    // ------------------------
    dbe_pkg::dbe_mode_t mode;
    dbe_pkg::dbe_mode_t next_mode;
    logic [7:0] bank_open;
    logic [7:0] next_bank_open;
    logic [15:0] rd_cnt;
    logic [15:0] next_rd_cnt;
    logic [15:0] wr_cnt;
    logic [15:0] next_wr_cnt;
    logic ctrl_en;
    logic next_ctrl_en;
    logic cmd_ok;
    logic is_rd;
    logic is_wr;
    logic [3:0] len;
    logic [3:0] rl;
    dbe_pkg::dbe_slot_t ins;
    logic [3:0] ins_idx;

    assign cmd_ok = tick & ctrl_en;
    assign is_rd = cmd_ok & (cmd == dbe_pkg::CMD_RD);
    assign is_wr = cmd_ok & (cmd == dbe_pkg::CMD_WR);
    assign len = mode.bl8 ? dbe_pkg::BEATS8 : dbe_pkg::BEATS4;
    assign rl = 4'(mode.al) + 4'(mode.cl);

    always_comb begin
        next_mode = mode;
        next_bank_open = bank_open;
        next_rd_cnt = rd_cnt;
        next_wr_cnt = wr_cnt;
        if (cmd_ok && cmd == dbe_pkg::CMD_MRS && p3.ba == dbe_pkg::BA_MR) begin
            if (p3.addr[2:0] == dbe_pkg::MR_BL4 || p3.addr[2:0] == dbe_pkg::MR_BL8) begin
                next_mode.bl8 = (p3.addr[2:0] == dbe_pkg::MR_BL8);
            end
            next_mode.intl = p3.addr[dbe_pkg::MR_BT_BIT];
            if (p3.addr[dbe_pkg::MR_CL_LSB +: 3] >= dbe_pkg::CL_MIN) begin
                next_mode.cl = p3.addr[dbe_pkg::MR_CL_LSB +: 3];
            end
        end
        if (cmd_ok && cmd == dbe_pkg::CMD_MRS && p3.ba == dbe_pkg::BA_EMR1) begin
            next_mode.al = p3.addr[dbe_pkg::EMR_AL_LSB +: 3];
        end
        if (cmd_ok && cmd == dbe_pkg::CMD_ACT) begin
            next_bank_open[p3.ba] = 1'b1;
        end
        if (cmd_ok && cmd == dbe_pkg::CMD_PRE) begin
            if (p3.addr[dbe_pkg::AP_BIT]) begin
                next_bank_open = '0;
            end else begin
                next_bank_open[p3.ba] = 1'b0;
            end
        end
        if (is_rd) begin
            next_rd_cnt = rd_cnt + 16'h1;
        end
        if (is_wr) begin
            next_wr_cnt = wr_cnt + 16'h1;
        end
    end

    always_comb begin
        ins = '{vld: is_rd | is_wr, wr: is_wr, col: p3.addr[3:0]};
        ins_idx = is_wr ? rl - dbe_pkg::WR_ADJ : rl - dbe_pkg::RD_ADJ;
    end

    // ------------------------
    // Latency line, one slot per DDR clock
    // ------------------------
    dbe_pkg::dbe_slot_t sr [dbe_pkg::SR_D];
    dbe_pkg::dbe_slot_t next_sr [dbe_pkg::SR_D];

    for (genvar i = 0; i < dbe_pkg::SR_D; i++) begin : g_sr
        always_comb begin
            next_sr[i] = sr[i];
            if (tick) begin
                next_sr[i] = (i == dbe_pkg::SR_D - 1) ? '0 : sr[(i + 1) % dbe_pkg::SR_D];
                if (ins.vld && ins_idx == 4'(i)) begin
                    next_sr[i] = ins;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < dbe_pkg::SR_D; i++) begin
                sr[i] <= '0;
            end
        end else begin
            sr <= next_sr;
        end
    end

    // ------------------------
    // Storage and burst ordering
    // ------------------------
    function automatic logic [3:0] beat_col(input logic [3:0] s, input logic [2:0] i,
                                           input logic intl);
        logic [2:0] o;
        if (intl) begin
            o = s[2:0] ^ i;
        end else begin
            o = {s[2] ^ i[2], 2'(s[1:0] + i[1:0])};
        end
        return {s[3], o};
    endfunction

    logic [15:0] mem [dbe_pkg::MEM_D];
    logic [15:0] next_mem [dbe_pkg::MEM_D];
    logic wen;
    logic [3:0] widx;

    always_comb begin
        next_mem = mem;
        for (int l = 0; l < dbe_pkg::LANES; l++) begin
            if (wen && !p3.dm[l]) begin
                next_mem[widx][l*8 +: 8] = p3.dq[l*8 +: 8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < dbe_pkg::MEM_D; i++) begin
                mem[i] <= '0;
            end
        end else begin
            mem <= next_mem;
        end
    end

    // ------------------------
    // Write capture
    // ------------------------
    dbe_pkg::dbe_wr_t wr_st;
    dbe_pkg::dbe_wr_t next_wr_st;
    logic [3:0] wcol;
    logic [3:0] next_wcol;
    logic [2:0] wbeat;
    logic [2:0] next_wbeat;
    logic [3:0] wleft;
    logic [3:0] next_wleft;
    logic start_wr;
    logic [3:0] cur_wcol;

    assign start_wr = tick & sr[0].vld & sr[0].wr;
    assign cur_wcol = start_wr ? sr[0].col : wcol;

    always_comb begin
        next_wr_st = wr_st;
        next_wcol = cur_wcol;
        next_wbeat = wbeat;
        next_wleft = wleft;
        wen = 1'b0;
        widx = beat_col(cur_wcol, wbeat, mode.intl);
        if (start_wr || wr_st == dbe_pkg::WR_ARM) begin
            next_wr_st = dbe_pkg::WR_ARM;
            if (dqs_rise) begin
                wen = 1'b1;
                widx = beat_col(cur_wcol, 3'h0, mode.intl);
                next_wbeat = 3'h1;
                next_wleft = len - 4'h1;
                next_wr_st = dbe_pkg::WR_BURST;
            end
        end else if (wr_st == dbe_pkg::WR_BURST && dqs_edge) begin
            wen = 1'b1;
            next_wbeat = wbeat + 3'h1;
            next_wleft = wleft - 4'h1;
            if (wleft == 4'h1) begin
                next_wr_st = dbe_pkg::WR_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_st <= dbe_pkg::WR_IDLE;
            wcol <= '0;
            wbeat <= '0;
            wleft <= '0;
        end else begin
            wr_st <= next_wr_st;
            wcol <= next_wcol;
            wbeat <= next_wbeat;
            wleft <= next_wleft;
        end
    end

    // ------------------------
    // Read drive
    // ------------------------
    dbe_pkg::dbe_rd_t rd_st;
    dbe_pkg::dbe_rd_t next_rd_st;
    logic [3:0] rcol;
    logic [3:0] next_rcol;
    logic [2:0] rbeat;
    logic [2:0] next_rbeat;
    logic [3:0] rleft;
    logic [3:0] next_rleft;
    logic [15:0] next_dq_out;
    logic next_dq_oe;
    logic next_dqs_out;
    logic next_dqs_oe;
    logic start_rd;
    logic pre_rd;

    assign start_rd = tick & sr[0].vld & ~sr[0].wr;
    assign pre_rd = tick & sr[1].vld & ~sr[1].wr;

    always_comb begin
        next_rd_st = rd_st;
        next_rcol = rcol;
        next_rbeat = rbeat;
        next_rleft = rleft;
        next_dq_out = dq_out;
        next_dq_oe = dq_oe;
        next_dqs_out = dqs_out;
        next_dqs_oe = dqs_oe;
        if (start_rd) begin
            next_rd_st = dbe_pkg::RD_BURST;
            next_rcol = sr[0].col;
            next_rbeat = 3'h1;
            next_rleft = len - 4'h1;
            next_dq_out = mem[beat_col(sr[0].col, 3'h0, mode.intl)];
            next_dq_oe = 1'b1;
            next_dqs_out = 1'b1;
            next_dqs_oe = 1'b1;
        end else if (ck_edge) begin
            if (rd_st == dbe_pkg::RD_BURST && rleft != 4'h0) begin
                next_dq_out = mem[beat_col(rcol, rbeat, mode.intl)];
                next_dqs_out = tick;
                next_rbeat = rbeat + 3'h1;
                next_rleft = rleft - 4'h1;
            end else if (pre_rd) begin
                next_rd_st = dbe_pkg::RD_PRE;
                next_dq_oe = 1'b0;
                next_dqs_out = 1'b0;
                next_dqs_oe = 1'b1;
            end else if (rd_st != dbe_pkg::RD_PRE) begin
                next_rd_st = dbe_pkg::RD_IDLE;
                next_dq_oe = 1'b0;
                next_dqs_out = 1'b0;
                next_dqs_oe = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_st <= dbe_pkg::RD_IDLE;
            rcol <= '0;
            rbeat <= '0;
            rleft <= '0;
            dq_out <= '0;
            dq_oe <= 1'b0;
            dqs_out <= 1'b0;
            dqs_oe <= 1'b0;
        end else begin
            rd_st <= next_rd_st;
            rcol <= next_rcol;
            rbeat <= next_rbeat;
            rleft <= next_rleft;
            dq_out <= next_dq_out;
            dq_oe <= next_dq_oe;
            dqs_out <= next_dqs_out;
            dqs_oe <= next_dqs_oe;
        end
    end

    // ------------------------
    // APB slave
    // ------------------------
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup;

    // Zero wait states: the answer is prepared during setup.
    assign setup = psel & ~penable;

    always_comb begin
        next_pready = setup;
        next_pslverr = 1'b0;
        next_prdata = '0;
        next_ctrl_en = ctrl_en;
        if (setup) begin
            case (paddr)
                dbe_pkg::REG_CTRL: begin
                    next_prdata = {31'h0, ctrl_en};
                end
                dbe_pkg::REG_MODE: begin
                    next_prdata = {24'h0, mode};
                end
                dbe_pkg::REG_BANKS: begin
                    next_prdata = {24'h0, bank_open};
                end
                dbe_pkg::REG_COUNT: begin
                    next_prdata = {wr_cnt, rd_cnt};
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
            if (pwrite) begin
                next_prdata = '0;
            end
        end
        if (psel && penable && pready && pwrite && paddr == dbe_pkg::REG_CTRL) begin
            next_ctrl_en = pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl_en <= dbe_pkg::CTRL_EN_RST;
            mode <= '{al: dbe_pkg::AL_RST, cl: dbe_pkg::CL_RST, intl: 1'b0, bl8: 1'b0};
            bank_open <= '0;
            rd_cnt <= '0;
            wr_cnt <= '0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            ctrl_en <= next_ctrl_en;
            mode <= next_mode;
            bank_open <= next_bank_open;
            rd_cnt <= next_rd_cnt;
            wr_cnt <= next_wr_cnt;
        end
    end

endmodule

// *** core/dbe_pkg.sv ***
/*
 * Shared constants and types of the burst access engine: pin bundle, latency slot,
 * mode fields, engine states and the register map.
 * Assumes one clock domain, pclk, and a DDR clock sampled as an ordinary input.
 */
// Overview of operation
// - Only burst lengths 4 and 8; address bit 3 at mode set picks order.
// - Beat columns: BL4 sequential mod 4, interleaved XOR, BL8 sequential nibble wrap.
// - Read decoded when select and column strobe low, row strobe and write high.
// - First read data appears additive plus column latency clocks after read.
// - Read strobe driven low one clock ahead; data aligned to strobe edges.
// - Reads every 4 clocks at burst length 8 give gapless data.
// - Writes every BL/2 clocks give gapless write bursts.
// - Write decoded when select, column strobe, write low and row strobe high.
// - Write latency equals read latency minus one clock.
// - Data after the programmed beats of a write burst is ignored.
// - One mask input per byte lane, sampled like write data.
// - Command spacing uses programmed burst length, not shortened burst.
// - Precharge decode; address bit 10 closes all banks, else bank address.
package dbe_pkg;

    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int ADDR_W = 14;
    localparam int BA_W = 3;
    localparam int MEM_D = 16;
    localparam int SR_D = 16;

    // ------------------------
    // Register map
    // ------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h04;
    localparam logic [7:0] REG_BANKS = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;
    localparam logic CTRL_EN_RST = 1'b1;

    // ------------------------
    // Command pins and mode fields
    // ------------------------
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [2:0] BA_MR = 3'h0;
    localparam logic [2:0] BA_EMR1 = 3'h1;
    localparam logic [2:0] MR_BL4 = 3'h2;
    localparam logic [2:0] MR_BL8 = 3'h3;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int EMR_AL_LSB = 3;
    localparam int AP_BIT = 10;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [2:0] CL_MIN = 3'h2;
    localparam logic [2:0] AL_RST = 3'h0;
    localparam logic [3:0] BEATS4 = 4'h4;
    localparam logic [3:0] BEATS8 = 4'h8;
    localparam logic [3:0] RD_ADJ = 4'h1;
    localparam logic [3:0] WR_ADJ = 4'h2;

    typedef struct packed {
        logic ck;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq;
        logic dqs;
        logic [LANES-1:0] dm;
    } dbe_pins_t;

    typedef struct packed {
        logic vld;
        logic wr;
        logic [3:0] col;
    } dbe_slot_t;

    typedef struct packed {
        logic [2:0] al;
        logic [2:0] cl;
        logic intl;
        logic bl8;
    } dbe_mode_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_PRE = 2'h1,
        RD_BURST = 2'h3
    } dbe_rd_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_ARM = 2'h1,
        WR_BURST = 2'h3
    } dbe_wr_t;

endpackage

// *** testbench/dbe_burst_props.sv ***
/*
 * Checker for the burst engine: read strobe, beat timing and APB answer.
 * Assumes pclk samples ck at a fixed 8:1 ratio; bound to dbe_burst below.
 */
`timescale 1ns/100ps
module dbe_burst_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    input wire logic dqs_out,
    input wire logic dqs_oe
);
    // ------------------------
    // Helper counters
    // ------------------------
    // The read age saturates, so a burst with no read behind it fails.
    logic [2:0] seen_q, next_seen_q;
    logic [7:0] since_rd, next_since_rd;
    logic [5:0] beats, next_beats;
    always_comb begin
        next_seen_q = {ck, dq_oe, dqs_out};
        next_since_rd = (since_rd == 8'hff) ? since_rd : since_rd + 8'h01;
        if (ck && !seen_q[2] && {cs_n, ras_n, cas_n, we_n} == dbe_pkg::CMD_RD) begin
            next_since_rd = 8'h00;
        end
        next_beats = dq_oe ? beats : 6'h00;
        if (dq_oe && (!seen_q[1] || dqs_out != seen_q[0])) begin
            next_beats = beats + 6'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 3'h0;
            since_rd <= 8'hff;
            beats <= 6'h00;
        end else begin
            seen_q <= next_seen_q;
            since_rd <= next_since_rd;
            beats <= next_beats;
        end
    end
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_preamble;
        (dqs_oe && !dqs_out && !dq_oe) [*8];
    endsequence
    sequence s_beat0;
        dq_oe && dqs_oe && dqs_out;
    endsequence
    pre_strobe_a: assert property ($rose(dqs_oe) |-> s_preamble ##1 s_beat0)
        else $error("read preamble is not one clock long");
    first_beat_a: assert property ($rose(dq_oe) |-> dqs_out && !$past(dqs_out))
        else $error("first beat not on a rising strobe");
    beat_hold_a: assert property (
        dq_oe && $past(dq_oe) && $changed(dqs_out) |=> $stable(dqs_out) [*3])
        else $error("read beat shorter than half a clock");
    data_align_a: assert property (
        dq_oe && $past(dq_oe) && $stable(dqs_out) |-> $stable(dq_out))
        else $error("read data moved without a strobe edge");
    oe_pair_a: assert property (dq_oe |-> dqs_oe)
        else $error("data driven without strobe");
    burst_len_a: assert property ($fell(dq_oe) |-> beats[1:0] == 2'b00 && beats >= 6'h04)
        else $error("read burst not a whole number of nibbles");
    read_cause_a: assert property ($rose(dqs_oe) |-> since_rd inside {[8'h02:8'h6e]})
        else $error("read strobe without a recent read command");
    apb_ready_a: assert property (psel && !penable |=> pready && penable)
        else $error("register access not answered at once");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
endmodule
bind dbe_burst dbe_burst_props u_dbe_burst_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .ck(ck), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe));

// *** testbench/dbe_burst_tb.sv ***
/*
 * Self-checking bench for dbe_burst: APB register tasks and DDR traffic through
 * the controller model, checked against a column-order model of the storage.
 */
`timescale 1ns/100ps
module dbe_burst_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_v;
    logic pready, pslverr, dq_oe, dqs_out, dqs_oe, dqs_w, rd_e;
    logic [15:0] dq_out, dq_w;
    logic [15:0] mem [16] = '{default: 16'h0};
    logic [15:0] rq [$];
    logic [15:0] eq [$];
    logic oe_q = 1'b0;
    logic dqs_q = 1'b0;
    logic bl8 = 1'b0;
    logic intl = 1'b0;
    int rl = 3;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_gap = 0;
    int m, g;
    realtime t_b0;
    dbe_pkg::dbe_pins_t pins;

    always #10 pclk = ~pclk;
    assign dq_w = dq_oe ? dq_out : pins.dq;
    assign dqs_w = dqs_oe ? dqs_out : pins.dqs;
    dbe_ctl_model u_dbe_ctl_model (.pins(pins));
    dbe_burst u_dbe_burst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ck(pins.ck), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .ba(pins.ba), .addr(pins.addr), .dq_in(dq_w),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_w), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
        .dm(pins.dm));

    // ------------------------
    // Read beat monitor and shared tasks
    // ------------------------
    always @(posedge pclk) begin
        if (dq_oe && (!oe_q || dqs_out != dqs_q)) begin
            rq.push_back(dq_out);
        end
        if (dq_oe && !oe_q) begin
            t_b0 = $realtime;
        end
        if (oe_q && !dq_oe) begin
            n_gap++;
        end
        oe_q <= dq_oe;
        dqs_q <= dqs_out;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic apb_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd_v, exp);
    endtask
    function automatic logic [3:0] col_of(input logic [3:0] s, input int i);
        logic [3:0] c;
        c = s ^ 4'(i);
        if (!intl) begin
            c[1:0] = s[1:0] + 2'(i);
        end
        return c;
    endfunction
    task automatic set_mode(input logic b8, input logic il, input logic [2:0] cl,
        input logic [2:0] al);
        bl8 = b8;
        intl = il;
        rl = cl + al;
        u_dbe_ctl_model.cmd(dbe_pkg::CMD_MRS, dbe_pkg::BA_MR, {7'h00, cl, il, 2'b01, b8});
        u_dbe_ctl_model.cmd(dbe_pkg::CMD_MRS, dbe_pkg::BA_EMR1, {8'h00, al, 3'h0});
        apb_chk(dbe_pkg::REG_MODE, {24'h0, al, cl, il, b8});
    endtask
    task automatic ddr_wr(input logic [3:0] s, input logic [15:0] base, input logic [1:0] msk);
        int i;
        logic [15:0] v;
        for (i = 0; i < (bl8 ? 8 : 4); i++) begin
            v = base + 16'(i);
            if (!msk[0]) mem[col_of(s, i)][7:0] = v[7:0];
            if (!msk[1]) mem[col_of(s, i)][15:8] = v[15:8];
        end
        u_dbe_ctl_model.wr(s, base, msk, bl8 ? 8 : 4, rl - 1);
    endtask
    task automatic ddr_rd(input logic [3:0] s, input int n);
        int i;
        for (i = 0; i < n; i++) eq.push_back(mem[col_of(s, i)]);
        u_dbe_ctl_model.cmd(dbe_pkg::CMD_RD, 3'h0, {10'h000, s});
    endtask
    task automatic drain(input bit lat);
        int k;
        for (k = 0; k < 600 && rq.size() < eq.size(); k++) @(posedge pclk);
        if (rq.size() < eq.size()) begin
            n_mismatch++;
            give_verdict();
        end
        repeat (8) @(posedge pclk);
        check(32'(rq.size()), 32'(eq.size()));
        for (k = 0; k < eq.size() && k < rq.size(); k++) check({16'h0, rq[k]}, {16'h0, eq[k]});
        if (lat) check(32'(int'(t_b0 - u_dbe_ctl_model.t_cmd) / 160), 32'(rl));
        rq.delete();
        eq.delete();
    endtask

    // ------------------------
    // Main sequence
    // ------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb_chk(dbe_pkg::REG_CTRL, 32'h1);
        apb_chk(dbe_pkg::REG_MODE, 32'h0000_000c);
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, rd_e}, 32'h1);
        check(rd_v, 32'h0);
        apb(1'b1, dbe_pkg::REG_CTRL, 32'h0);
        ddr_rd(4'h0, 0);
        repeat (80) @(posedge pclk);
        drain(1'b0);
        apb(1'b1, dbe_pkg::REG_CTRL, 32'h1);
        u_dbe_ctl_model.cmd(dbe_pkg::CMD_ACT, 3'h5, 14'h0000);
        u_dbe_ctl_model.cmd(dbe_pkg::CMD_ACT, 3'h2, 14'h0000);
        apb_chk(dbe_pkg::REG_BANKS, 32'h24);
        u_dbe_ctl_model.cmd(dbe_pkg::CMD_PRE, 3'h5, 14'h0000);
        apb_chk(dbe_pkg::REG_BANKS, 32'h04);
        u_dbe_ctl_model.cmd(dbe_pkg::CMD_PRE, 3'h0, 14'h0400);
        apb_chk(dbe_pkg::REG_BANKS, 32'h0);
        $display("registers and banks done");
        // Each read waits until the write data has fully passed.
        for (m = 0; m < 4; m++) begin
            set_mode(m[1], m[0], 3'h3, 3'h0);
            ddr_wr(4'(m * 3 + 5), 16'(m * 16'h1110 + 16'h0100), 2'b00);
            ddr_rd(4'(m * 5 + 2), bl8 ? 8 : 4);
            drain(1'b1);
        end
        $display("burst orders done");
        set_mode(1'b0, 1'b0, 3'h3, 3'h0);
        ddr_wr(4'h8, 16'h5a10, 2'b01);
        ddr_wr(4'h9, 16'h3c20, 2'b10);
        ddr_rd(4'h8, 4);
        drain(1'b1);
        set_mode(1'b0, 1'b0, 3'h4, 3'h1);
        ddr_wr(4'h0, 16'h7700, 2'b00);
        ddr_rd(4'h0, 4);
        drain(1'b1);
        $display("mask and latency done");
        set_mode(1'b1, 1'b0, 3'h3, 3'h0);
        g = n_gap;
        ddr_rd(4'h0, 8);
        repeat (2) @(negedge pins.ck);
        ddr_rd(4'h8, 8);
        drain(1'b0);
        check(32'(n_gap - g), 32'h1);
        // A read two clocks later cuts an eight-beat read after four beats.
        ddr_rd(4'h0, 4);
        ddr_rd(4'h8, 8);
        drain(1'b0);
        u_dbe_ctl_model.cmd(dbe_pkg::CMD_MRS, dbe_pkg::BA_MR, 14'h0031);
        apb_chk(dbe_pkg::REG_MODE, 32'h0000_000d);
        apb_chk(dbe_pkg::REG_COUNT, 32'h0007_000a);
        $display("gapless and interrupt done");
        give_verdict();
    end
endmodule

// *** testbench/dbe_ctl_model.sv ***
/*
 * Behavioural memory controller: free-running link clock, commands, write data.
 * Assumes the bench calls its tasks one at a time from a single process.
 */
`timescale 1ns/100ps
module dbe_ctl_model (
    output dbe_pkg::dbe_pins_t pins
);
    realtime t_cmd;
    initial begin
        pins = '0;
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hf;
        #13;
        forever #80 pins.ck = ~pins.ck;
    end
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(negedge pins.ck);
        // Pins set half a clock ahead of the sampling edge.
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
        pins.ba <= b;
        pins.addr <= a;
        @(posedge pins.ck);
        t_cmd = $realtime;
        @(negedge pins.ck);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
        pins.ba <= ~b;
        pins.addr <= ~a;
    endtask
    // Two spare beats follow every burst, so a device that keeps capturing is caught.
    task automatic wr(input logic [3:0] col, input logic [15:0] base, input logic [1:0] msk,
        input int n, input int wl);
        int i;
        cmd(dbe_pkg::CMD_WR, 3'h0, {10'h000, col});
        repeat (wl - 1) @(posedge pins.ck);
        // Strobe preamble, then one beat on each strobe edge.
        @(negedge pins.ck) pins.dqs <= 1'b0;
        @(posedge pins.ck);
        for (i = 0; i < n + 2; i++) begin
            pins.dq <= (i < n) ? base + 16'(i) : ~(base + 16'(i));
            pins.dm <= (i < n) ? msk : 2'b00;
            #40 pins.dqs <= ~pins.dqs;
            #40;
        end
        pins.dq <= ~pins.dq;
    endtask
endmodule
